/* testbench/tcw_pin_model.sv */
// Port pin side model: measures period and high time of one pin
`timescale 1ns/1ps
module tcw_pin_model (
   input wire logic clk_sys,
   input wire logic pin,
   output logic [15:0] period,
   output logic [15:0] high_len
);
   logic last_q = 1'b0;
   logic [15:0] since_q = '0;
   initial begin
      period = '0;
      high_len = '0;
   end
   // =====================================
   // Edge timing, counted in clock cycles
   always @(posedge clk_sys) begin
      last_q <= pin;
      since_q <= since_q + 16'h0001;
      if (pin && !last_q) begin
         period <= since_q + 16'h0001;
         since_q <= '0;
      end
      if (!pin && last_q) begin
         high_len <= since_q + 16'h0001;
      end
   end
endmodule : tcw_pin_model

/* testbench/timer_compare_waveform_split_tb.sv */
// Self-checking bench for the timer compare and waveform block
`timescale 1ns/1ps
module timer_compare_waveform_split_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   tcw_pkg::tcw_bus_s req = '0;
   logic [7:0] bus_rdata;
   logic count_event_in = 1'b0;
   logic [5:0] port_out_value = '0;
   logic [5:0] pin_invert_enable = '0;
   logic [5:0] waveform_output;
   logic [15:0] period, high_len, w, per, cmp;
   logic [2:0] mode;
   int n_fail = 0;
   int compares = 0;
   int seed = 90047;
   always #5 clk_sys = ~clk_sys;
   tcw_timer tcw_timer_i (.clk_sys(clk_sys), .rst(rst), .req(req),
      .bus_rdata(bus_rdata), .count_event_in(count_event_in),
      .port_out_value(port_out_value),
      .pin_invert_enable(pin_invert_enable),
      .waveform_output(waveform_output));
   tcw_pin_model tcw_pin_model_i (.clk_sys(clk_sys),
      .pin(waveform_output[0]), .period(period), .high_len(high_len));
   // =====================================
   // Bus tasks and compares
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      @(negedge clk_sys);
      d = bus_rdata;
   endtask : rd
   // Low byte first: it goes through the temp byte
   task automatic w16(input logic [5:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 6'h01, d[15:8]);
   endtask : w16
   task automatic r16(input logic [5:0] a, output logic [15:0] d);
      rd(a, d[7:0]);
      rd(a + 6'h01, d[15:8]);
   endtask : r16
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] exp_period(input logic [2:0] m,
      input logic [15:0] p, input logic [15:0] c);
      if (m == tcw_pkg::WG_FRQ) return 16'h0002 * (c + 16'h0001);
      if (m == tcw_pkg::WG_SS) return p + 16'h0001;
      return 16'h0002 * p;
   endfunction : exp_period
   function automatic logic [15:0] exp_high(input logic [2:0] m,
      input logic [15:0] p, input logic [15:0] c);
      if (m == tcw_pkg::WG_FRQ) return c + 16'h0001;
      if (m == tcw_pkg::WG_SS) return c + 16'h0001;
      return 16'h0002 * c;
   endfunction : exp_high
   task automatic report_and_stop();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #400000;
      n_fail++;
      report_and_stop();
   end
   // =====================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      r16(6'h26, w);
      chk(w, tcw_pkg::PER_RST);
      rd(6'h08, w[7:0]);
      chk({8'h00, w[7:0]}, 16'h0000);
      for (int i = 0; i < 9; i++) begin
         mode = (i % 3 == 0) ? tcw_pkg::WG_SS :
            (i % 3 == 1) ? tcw_pkg::WG_FRQ :
            (i < 6) ? tcw_pkg::WG_DSBOT : tcw_pkg::WG_DSTOP;
         per = 16'h0003 + 16'($unsigned($random(seed)) % 8);
         cmp = 16'h0001 + 16'($unsigned($random(seed)) % (per - 1));
         wr(tcw_pkg::A_CTRLA, 8'h00);
         wr(tcw_pkg::A_INTFLAGS, 8'hff);
         wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h08);
         w16(6'h26, per);
         w16(6'h28, cmp);
         wr(tcw_pkg::A_CTRLB, {5'b00010, mode});
         wr(tcw_pkg::A_CTRLA, 8'h01);
         repeat (60) @(posedge clk_sys);
         chk(period, exp_period(mode, per, cmp));
         chk(high_len, exp_high(mode, per, cmp));
         rd(tcw_pkg::A_INTFLAGS, w[7:0]);
         chk({8'h00, w[7:0] & 8'h10}, 16'h0010);
      end
      wr(tcw_pkg::A_CTRLB, 8'h03);
      port_out_value <= 6'($random(seed));
      pin_invert_enable <= 6'($random(seed));
      repeat (3) @(posedge clk_sys);
      chk({10'h000, waveform_output},
         {10'h000, port_out_value ^ pin_invert_enable});
      wr(tcw_pkg::A_CTRLB, 8'h13);
      wr(tcw_pkg::A_EVCTRL, 8'h01);
      repeat (3) @(posedge clk_sys);
      chk({15'h0000, waveform_output[0]},
         {15'h0000, port_out_value[0] ^ pin_invert_enable[0]});
      wr(tcw_pkg::A_EVCTRL, 8'h00);
      wr(tcw_pkg::A_CTRLA, 8'h00);
      w16(6'h20, 16'h1234);
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h08);
      r16(6'h20, w);
      chk(w, 16'h0000);
      w16(6'h26, 16'h0055);
      wr(tcw_pkg::A_CTRLA, 8'h01);
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h0c);
      wr(tcw_pkg::A_CTRLA, 8'h00);
      r16(6'h26, w);
      chk(w, 16'h0055);
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h0c);
      r16(6'h26, w);
      chk(w, tcw_pkg::PER_RST);
      // Buffered words: the lock holds them back, unlock or command applies
      w16(6'h26, 16'h0007);
      w16(6'h28, 16'h0002);
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h02);
      w16(6'h36, 16'h0006);
      w16(6'h38, 16'h0005);
      wr(tcw_pkg::A_CTRLA, 8'h01);
      repeat (20) @(posedge clk_sys);
      r16(6'h28, w);
      chk(w, 16'h0002);
      rd(tcw_pkg::A_CTRLFSET, w[7:0]);
      chk({8'h00, w[7:0]}, 16'h0003);
      wr(tcw_pkg::A_CTRLECLR, 8'h02);
      repeat (20) @(posedge clk_sys);
      r16(6'h28, w);
      chk(w, 16'h0005);
      r16(6'h26, w);
      chk(w, 16'h0006);
      rd(tcw_pkg::A_CTRLFSET, w[7:0]);
      chk({8'h00, w[7:0]}, 16'h0000);
      wr(tcw_pkg::A_CTRLA, 8'h00);
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h02);
      w16(6'h36, 16'h0009);
      w16(6'h38, 16'h0003);
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h04);
      r16(6'h28, w);
      chk(w, 16'h0003);
      r16(6'h26, w);
      chk(w, 16'h0009);
      // Stop and hard reset before changing mode
      wr(tcw_pkg::A_CONTROL_E_SET_REGISTER, 8'h0c);
      // Split start order: split bit, low period and low compare bytes, then enable
      wr(tcw_pkg::A_CTRLD, 8'h01);
      wr(6'h26, 8'h03);
      wr(6'h28, 8'h01);
      wr(tcw_pkg::A_CTRLB, 8'h13);
      wr(tcw_pkg::A_CTRLA, 8'h01);
      repeat (40) @(posedge clk_sys);
      chk(period, 16'h0004);
      chk(high_len, pin_invert_enable[0] ? 16'h0003 : 16'h0001);
      report_and_stop();
   end
endmodule : timer_compare_waveform_split_tb

/* verilog/tcw_pkg.sv */
// Constants, state and bus types for the timer compare and waveform block
// Behaviour
// RULE1 - A counter/compare match flags a match; its flag sets one cycle later
// RULE2 - Buffered compare values reach the active value only on update
// RULE3 - Waveform needs a waveform mode, clock counting and output enable
// RULE4 - An enabled waveform channel replaces the pin output value
// RULE5 - Frequency mode: compare sets period, output toggles on each match
// RULE6 - Frequency mode half period is compare plus one ticks
// RULE7 - Single slope: count up, set at top, clear on match
// RULE8 - Single slope period is period value plus one ticks
// RULE9 - Dual slope: set at bottom, clear on up match, set on down match
// RULE10 - Dual slope runs up then down, period twice the period value
// RULE11 - Commands come from the control set register and act at once
// RULE12 - Update command equals a natural update and ignores the lock
// RULE13 - Restart clears counter, direction and all compare outputs
// RULE14 - Reset command restores all registers, ignored while enabled
// RULE15 - Split mode gives two 8-bit timers with three channels each
// RULE16 - Split counters count down only, single slope, no event actions
// RULE17 - Split: high byte has underflow flag, no compare flags
// RULE18 - Split: buffers and temp byte unused, byte access to all registers
// RULE19 - Software should disable and reset before changing split mode
// RULE20 - Split start: split bit, then periods, then enable
// RULE21 - Update happens at bottom or top, depending on the waveform mode
// RULE22 - Buffer valid sets on buffer write, clears when update copies it
// RULE23 - Command codes: none, update, restart, reset; zero does nothing
package tcw_pkg;
   localparam logic [5:0] A_CTRLA = 6'h00;
   localparam logic [5:0] A_CTRLB = 6'h01;
   localparam logic [5:0] A_CTRLD = 6'h03;
   localparam logic [5:0] A_CTRLECLR = 6'h04;
   localparam logic [5:0] A_CONTROL_E_SET_REGISTER = 6'h05;
   localparam logic [5:0] A_CTRLFCLR = 6'h06;
   localparam logic [5:0] A_CTRLFSET = 6'h07;
   localparam logic [5:0] A_EVCTRL = 6'h09;
   localparam logic [5:0] A_INTFLAGS = 6'h0b;
   localparam logic [5:0] A_TEMP = 6'h0f;
   // 16-bit words: counter, period, compares, period buffer, compare buffers
   localparam int NW = 9;
   localparam int W_CNT = 0;
   localparam int W_PER = 1;
   localparam int W_CMP0 = 2;
   localparam int W_PBUF = 5;
   localparam int W_CBUF0 = 6;
   localparam logic [NW-1:0][5:0] W_ADDR = {6'h3c, 6'h3a, 6'h38, 6'h36,
      6'h2c, 6'h2a, 6'h28, 6'h26, 6'h20};
   localparam logic [15:0] PER_RST = 16'hffff;
   // Field positions
   localparam int CA_EN = 0;
   localparam int CA_CLK = 1;
   localparam int CB_HEN = 0;
   localparam int CB_EN = 4;
   localparam int E_DIR = 0;
   localparam int E_UPDATE_LOCK = 1;
   localparam int E_CMD = 2;
   localparam int EV_COUNT_EVENT_INPUT_ENABLE = 0;
   localparam int EV_ACT = 1;
   localparam int F_OVF = 0;
   localparam int F_HUNF = 1;
   localparam int F_CMP0 = 4;
   localparam logic [2:0] WG_NORMAL = 3'h0;
   localparam logic [2:0] WG_FRQ = 3'h1;
   localparam logic [2:0] WG_SS = 3'h3;
   localparam logic [2:0] WG_DSTOP = 3'h5;
   localparam logic [2:0] WG_DSBOT = 3'h7;
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_UPD = 2'h1;
   localparam logic [1:0] CMD_RESTART = 2'h2;
   localparam logic [1:0] CMD_RESET = 2'h3;
   localparam logic [1:0] EVA_RISE = 2'h0;
   localparam logic [1:0] EVA_EDGE = 2'h1;
   localparam logic [1:0] EVA_HIGH = 2'h2;
   // Prescaler masks for dividers 1,2,4,8,16,64,256,1024
   localparam logic [7:0][9:0] PSC_MASK = {10'h3ff, 10'h0ff, 10'h03f,
      10'h00f, 10'h007, 10'h003, 10'h001, 10'h000};

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcw_bus_s;

   typedef struct packed {
      logic [NW-1:0][15:0] w;
      logic [3:0] bv;
      logic [7:0] temp;
      logic en;
      logic [2:0] prescaler_select;
      logic [7:0] ctrlb;
      logic split;
      logic dir;
      logic update_lock;
      logic count_event_input_enable;
      logic [1:0] evact;
      logic [7:0] flags;
      logic [7:0] pend;
      logic [9:0] psc;
      logic [2:0] ev;
      logic [5:0] wave;
      logic [5:0] pin;
      logic [7:0] rdata;
   } tcw_state_s;

   function automatic tcw_state_s tcw_rst_f();
      tcw_state_s s;
      s = '0;
      s.w[W_PER] = PER_RST;
      return s;
   endfunction : tcw_rst_f

   localparam tcw_state_s ST_RST = tcw_rst_f();
endpackage : tcw_pkg

/* verilog/tcw_timer.sv */
// Timer compare channels, waveform generation, commands and split mode
`timescale 1ns/1ps
module tcw_timer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire tcw_pkg::tcw_bus_s req,
   output logic [7:0] bus_rdata,
   input wire logic count_event_in,
   input wire logic [5:0] port_out_value,
   input wire logic [5:0] pin_invert_enable,
   output logic [5:0] waveform_output
);
   tcw_pkg::tcw_state_s q;
   tcw_pkg::tcw_state_s d;
   logic [1:0] cmd;
   logic ptick;
   logic tick;
   logic use_ev;
   logic ev_rise;
   logic ev_edge;
   logic [2:0] wg;
   logic is_ds;
   logic wave_ok;
   logic [15:0] cnt;
   logic [15:0] top_v;
   logic at_top;
   logic at_bot;
   logic lo_bot;
   logic hi_bot;
   logic ovf;
   logic upd_nat;
   logic upd_go;
   logic [5:0] hit;
   logic [5:0] ovr;
   logic [7:0] clr;

   assign bus_rdata = q.rdata;
   assign waveform_output = q.pin;

   // =====================================================
   // Next state
   always_comb begin
      d = q;
      d.rdata = 8'h00;
      d.pend = 8'h00;
      clr = 8'h00;
      ovf = 1'b0;
      upd_nat = 1'b0;
      cmd = tcw_pkg::CMD_NONE;
      if (req.wr && req.addr == tcw_pkg::A_CONTROL_E_SET_REGISTER) begin
         cmd = req.wdata[tcw_pkg::E_CMD +: 2]; // RULE11 RULE23
      end
      // Event pin synchroniser; edges compare the second and third stages
      d.ev = {q.ev[1:0], count_event_in};
      ev_rise = q.ev[1] & ~q.ev[2];
      ev_edge = q.ev[1] ^ q.ev[2];
      d.psc = q.en ? q.psc + 10'h001 : 10'h000;
      ptick = q.en && ((q.psc & tcw_pkg::PSC_MASK[q.prescaler_select]) ==
         tcw_pkg::PSC_MASK[q.prescaler_select]);
      // Split mode never counts events
      use_ev = q.count_event_input_enable && !q.split; // RULE16
      if (!use_ev) begin
         tick = ptick;
      end else if (q.evact == tcw_pkg::EVA_EDGE) begin
         tick = q.en && ev_edge;
      end else if (q.evact == tcw_pkg::EVA_HIGH) begin
         tick = ptick && q.ev[1];
      end else begin
         tick = q.en && ev_rise;
      end
      wg = q.ctrlb[2:0];
      is_ds = wg >= tcw_pkg::WG_DSTOP;
      wave_ok = (q.split || wg != tcw_pkg::WG_NORMAL) && !use_ev; // RULE3
      cnt = q.w[tcw_pkg::W_CNT];
      // Frequency mode takes its period from channel 0's compare
      top_v = (wg == tcw_pkg::WG_FRQ) ? q.w[tcw_pkg::W_CMP0] :
         q.w[tcw_pkg::W_PER]; // RULE5
      at_top = cnt == top_v;
      at_bot = cnt == 16'h0000;
      lo_bot = cnt[7:0] == 8'h00;
      hi_bot = cnt[15:8] == 8'h00;
      for (int i = 0; i < 3; i++) begin
         if (q.split) begin
            hit[i] = cnt[7:0] == q.w[tcw_pkg::W_CMP0 + i][7:0];
            hit[i + 3] = cnt[15:8] == q.w[tcw_pkg::W_CMP0 + i][15:8];
         end else begin
            hit[i] = cnt == q.w[tcw_pkg::W_CMP0 + i]; // RULE1
            hit[i + 3] = 1'b0;
         end
      end

      // =====================================================
      // Counting and waveforms, normal mode
      if (tick && !q.split) begin
         if (is_ds) begin
            // Turn at both ends: 2 x period ticks per cycle
            if (!q.dir) begin
               if (at_top) begin
                  d.dir = 1'b1;
                  d.w[tcw_pkg::W_CNT] = cnt - 16'h0001; // RULE10
               end else begin
                  d.w[tcw_pkg::W_CNT] = cnt + 16'h0001;
               end
            end else if (at_bot) begin
               d.dir = 1'b0;
               d.w[tcw_pkg::W_CNT] = cnt + 16'h0001; // RULE10
            end else begin
               d.w[tcw_pkg::W_CNT] = cnt - 16'h0001;
            end
            ovf = (at_top && !q.dir && wg != tcw_pkg::WG_DSBOT) ||
               (at_bot && q.dir && wg != tcw_pkg::WG_DSTOP); // RULE21
         end else if (!q.dir) begin
            // Wrap after top: period + 1 ticks
            d.w[tcw_pkg::W_CNT] = at_top ? 16'h0000 : cnt + 16'h0001; // RULE8
            ovf = at_top; // RULE21
         end else begin
            d.w[tcw_pkg::W_CNT] = at_bot ? top_v : cnt - 16'h0001;
            ovf = at_bot; // RULE21
         end
         upd_nat = ovf;
         d.pend[tcw_pkg::F_OVF] = ovf;
         for (int i = 0; i < 3; i++) begin
            d.pend[tcw_pkg::F_CMP0 + i] = hit[i]; // RULE1
            case (wg)
               tcw_pkg::WG_FRQ: begin
                  if (hit[i]) begin
                     d.wave[i] = ~q.wave[i]; // RULE5 RULE6
                  end
               end
               tcw_pkg::WG_SS: begin
                  if (hit[i]) begin
                     d.wave[i] = 1'b0; // RULE7
                  end
                  if (at_top) begin
                     d.wave[i] = 1'b1; // RULE7
                  end
               end
               default: begin
                  if (is_ds) begin
                     if (hit[i]) begin
                        d.wave[i] = q.dir; // RULE9
                     end
                     if (at_bot) begin
                        d.wave[i] = 1'b1; // RULE9
                     end
                  end
               end
            endcase
         end
      end

      // =====================================================
      // Counting and waveforms, split mode
      if (tick && q.split) begin
         d.w[tcw_pkg::W_CNT][7:0] = lo_bot ? q.w[tcw_pkg::W_PER][7:0] :
            cnt[7:0] - 8'h01; // RULE15 RULE16
         d.w[tcw_pkg::W_CNT][15:8] = hi_bot ? q.w[tcw_pkg::W_PER][15:8] :
            cnt[15:8] - 8'h01; // RULE15 RULE16
         d.pend[tcw_pkg::F_OVF] = lo_bot; // RULE17
         d.pend[tcw_pkg::F_HUNF] = hi_bot; // RULE17
         for (int i = 0; i < 3; i++) begin
            // High-byte channels never raise a flag
            d.pend[tcw_pkg::F_CMP0 + i] = hit[i]; // RULE17
            // Down-count single slope: set at match, clear at reload
            if (hit[i]) begin
               d.wave[i] = 1'b1;
            end
            if (hit[i + 3]) begin
               d.wave[i + 3] = 1'b1;
            end
            if (lo_bot) begin
               d.wave[i] = 1'b0; // RULE16
            end
            if (hi_bot) begin
               d.wave[i + 3] = 1'b0; // RULE16
            end
         end
      end

      // =====================================================
      // Update: buffers unused in split mode
      upd_go = ((upd_nat && !q.update_lock) || cmd == tcw_pkg::CMD_UPD) &&
         !q.split; // RULE12 RULE18
      if (upd_go) begin
         if (q.bv[0]) begin
            d.w[tcw_pkg::W_PER] = q.w[tcw_pkg::W_PBUF]; // RULE2
         end
         for (int i = 0; i < 3; i++) begin
            if (q.bv[i + 1]) begin
               d.w[tcw_pkg::W_CMP0 + i] = q.w[tcw_pkg::W_CBUF0 + i]; // RULE2
            end
         end
         d.bv = 4'h0; // RULE22
      end
      if (cmd == tcw_pkg::CMD_RESTART) begin
         d.w[tcw_pkg::W_CNT] = 16'h0000; // RULE13
         d.dir = 1'b0;
         d.wave = 6'h00;
      end

      // =====================================================
      // Register writes; a counter write beats counting
      if (req.wr) begin
         case (req.addr)
            tcw_pkg::A_CTRLA: begin
               d.en = req.wdata[tcw_pkg::CA_EN];
               d.prescaler_select = req.wdata[tcw_pkg::CA_CLK +: 3];
            end
            tcw_pkg::A_CTRLB: begin
               d.ctrlb = req.wdata;
            end
            tcw_pkg::A_CTRLD: begin
               d.split = req.wdata[0];
            end
            tcw_pkg::A_CTRLECLR: begin
               if (req.wdata[tcw_pkg::E_DIR]) begin
                  d.dir = 1'b0;
               end
               if (req.wdata[tcw_pkg::E_UPDATE_LOCK]) begin
                  d.update_lock = 1'b0;
               end
            end
            tcw_pkg::A_CONTROL_E_SET_REGISTER: begin
               if (req.wdata[tcw_pkg::E_DIR]) begin
                  d.dir = 1'b1;
               end
               if (req.wdata[tcw_pkg::E_UPDATE_LOCK]) begin
                  d.update_lock = 1'b1;
               end
            end
            tcw_pkg::A_CTRLFCLR: begin
               d.bv = d.bv & ~req.wdata[3:0];
            end
            tcw_pkg::A_CTRLFSET: begin
               d.bv = d.bv | req.wdata[3:0];
            end
            tcw_pkg::A_EVCTRL: begin
               d.count_event_input_enable = req.wdata[tcw_pkg::EV_COUNT_EVENT_INPUT_ENABLE];
               d.evact = req.wdata[tcw_pkg::EV_ACT +: 2];
            end
            tcw_pkg::A_INTFLAGS: begin
               clr = req.wdata;
            end
            tcw_pkg::A_TEMP: begin
               d.temp = req.wdata;
            end
            default: begin
            end
         endcase
         for (int i = 0; i < tcw_pkg::NW; i++) begin
            if (req.addr[5:1] == tcw_pkg::W_ADDR[i][5:1]) begin
               if (q.split) begin
                  // Plain byte access, buffers ignored
                  if (i < tcw_pkg::W_PBUF) begin
                     if (req.addr[0]) begin
                        d.w[i][15:8] = req.wdata; // RULE18
                     end else begin
                        d.w[i][7:0] = req.wdata; // RULE18
                     end
                  end
               end else if (!req.addr[0]) begin
                  d.temp = req.wdata;
               end else begin
                  // High byte write commits both bytes at once
                  d.w[i] = {req.wdata, q.temp};
                  if (i >= tcw_pkg::W_PBUF) begin
                     d.bv[i - tcw_pkg::W_PBUF] = 1'b1; // RULE22
                  end
               end
            end
         end
      end
      // A flag raised in the clearing cycle survives
      d.flags = (q.flags & ~clr) | q.pend;

      // =====================================================
      // Register reads
      if (req.rd) begin
         case (req.addr)
            tcw_pkg::A_CTRLA: begin
               d.rdata = {4'h0, q.prescaler_select, q.en};
            end
            tcw_pkg::A_CTRLB: begin
               d.rdata = q.ctrlb;
            end
            tcw_pkg::A_CTRLD: begin
               d.rdata = {7'h00, q.split};
            end
            tcw_pkg::A_CTRLECLR, tcw_pkg::A_CONTROL_E_SET_REGISTER: begin
               d.rdata = {6'h00, q.update_lock, q.dir};
            end
            tcw_pkg::A_CTRLFCLR, tcw_pkg::A_CTRLFSET: begin
               d.rdata = {4'h0, q.bv};
            end
            tcw_pkg::A_EVCTRL: begin
               d.rdata = {5'h00, q.evact, q.count_event_input_enable};
            end
            tcw_pkg::A_INTFLAGS: begin
               d.rdata = q.flags;
            end
            tcw_pkg::A_TEMP: begin
               d.rdata = q.temp;
            end
            default: begin
               d.rdata = 8'h00;
            end
         endcase
         for (int i = 0; i < tcw_pkg::NW; i++) begin
            if (req.addr[5:1] == tcw_pkg::W_ADDR[i][5:1]) begin
               if (q.split) begin
                  d.rdata = req.addr[0] ? q.w[i][15:8] : q.w[i][7:0];
               end else if (!req.addr[0]) begin
                  // Low byte read freezes the high byte for later
                  d.rdata = q.w[i][7:0];
                  d.temp = q.w[i][15:8];
               end else begin
                  d.rdata = q.temp;
               end
            end
         end
      end

      // =====================================================
      // Pin override
      for (int i = 0; i < 6; i++) begin
         if (i < 3) begin
            ovr[i] = wave_ok && q.ctrlb[tcw_pkg::CB_EN + i]; // RULE3
         end else begin
            ovr[i] = wave_ok && q.split &&
               q.ctrlb[tcw_pkg::CB_HEN + i - 3]; // RULE15
         end
         d.pin[i] = (ovr[i] ? q.wave[i] : port_out_value[i]) ^
            pin_invert_enable[i]; // RULE4
      end
      // Reset only while stopped; refused silently when running
      if (cmd == tcw_pkg::CMD_RESET && !q.en) begin
         d = tcw_pkg::ST_RST; // RULE14
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= tcw_pkg::ST_RST;
      end else begin
         q <= d;
      end
   end

   // =====================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_hit0;
      tick && !q.split && hit[0];
   endsequence
   sequence s_quiet;
      !req.wr;
   endsequence

   property p_flag_delay;
      s_hit0 ##1 s_quiet |=> q.flags[tcw_pkg::F_CMP0];
   endproperty
   a_flag_delay: assert property (p_flag_delay) // RULE1
      else $error("compare flag not set one cycle after match");

   property p_upd_copy;
      upd_nat && !q.update_lock && !q.split && q.bv[1] && !req.wr |=>
         q.w[tcw_pkg::W_CMP0] == $past(q.w[tcw_pkg::W_CBUF0]) && !q.bv[1];
   endproperty
   a_upd_copy: assert property (p_upd_copy) // RULE2
      else $error("compare buffer not copied on update");

   property p_lock_hold;
      upd_nat && q.update_lock && q.bv[1] && !req.wr |=> q.bv[1];
   endproperty
   a_lock_hold: assert property (p_lock_hold) // RULE22
      else $error("locked update consumed the buffer");

   property p_upd_cmd;
      cmd == tcw_pkg::CMD_UPD && q.update_lock && !q.split && q.bv[0] |=>
         q.w[tcw_pkg::W_PER] == $past(q.w[tcw_pkg::W_PBUF]) && !q.bv[0];
   endproperty
   a_upd_cmd: assert property (p_upd_cmd) // RULE12
      else $error("update command blocked by lock");

   property p_override;
      ovr[0] && cmd != tcw_pkg::CMD_RESET |=> waveform_output[0] ==
         ($past(q.wave[0]) ^ $past(pin_invert_enable[0]));
   endproperty
   a_override: assert property (p_override) // RULE4
      else $error("pin not driven by waveform");

   property p_no_wave;
      !wave_ok && cmd != tcw_pkg::CMD_RESET |=> waveform_output[0] ==
         ($past(port_out_value[0]) ^ $past(pin_invert_enable[0]));
   endproperty
   a_no_wave: assert property (p_no_wave) // RULE3
      else $error("waveform reached pin without a waveform mode");

   property p_frq;
      tick && !q.split && wg == tcw_pkg::WG_FRQ && hit[0] &&
         cmd == tcw_pkg::CMD_NONE |=> q.wave[0] != $past(q.wave[0]);
   endproperty
   a_frq: assert property (p_frq) // RULE5
      else $error("frequency output did not toggle on match");

   property p_ss_top;
      tick && !q.split && wg == tcw_pkg::WG_SS && at_top &&
         cmd == tcw_pkg::CMD_NONE |=> q.wave[0];
   endproperty
   a_ss_top: assert property (p_ss_top) // RULE7
      else $error("single slope output not set at top");

   property p_ds_down;
      tick && !q.split && is_ds && q.dir && hit[0] &&
         cmd == tcw_pkg::CMD_NONE |=> q.wave[0];
   endproperty
   a_ds_down: assert property (p_ds_down) // RULE9
      else $error("dual slope output not set on down match");

   property p_restart;
      cmd == tcw_pkg::CMD_RESTART |=>
         q.w[tcw_pkg::W_CNT] == 16'h0000 && !q.dir && q.wave == 6'h00;
   endproperty
   a_restart: assert property (p_restart) // RULE13
      else $error("restart left counter or outputs set");

   property p_reset_ign;
      cmd == tcw_pkg::CMD_RESET && q.en |=> q.en;
   endproperty
   a_reset_ign: assert property (p_reset_ign) // RULE14
      else $error("reset command acted while running");

   property p_split_down;
      tick && q.split && !lo_bot && !req.wr |=>
         q.w[tcw_pkg::W_CNT][7:0] == $past(cnt[7:0]) - 8'h01;
   endproperty
   a_split_down: assert property (p_split_down) // RULE16
      else $error("split low counter did not count down");
endmodule : tcw_timer
